// *** src/pin_status_pkg.sv ***
/*
 * Constants for the low pin status bank: register indices and byte
 * addresses, field layout of the two pin-configuration registers,
 * reset values and the bus slave state encoding.
 * Assumes a 32-bit APB with byte addressing; each register takes one
 * aligned word at four times its index.
 */
package pin_status_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PIN_COUNT = 8;
    localparam int REG_W = 8;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PIN_STATUS = 8'h21;
    localparam logic [7:0] IDX_PIN_CFG_A = 8'h10;
    localparam logic [7:0] IDX_PIN_CFG_B = 8'h11;
    localparam logic [ADDR_W-1:0] ADDR_PIN_STATUS = {2'h0, IDX_PIN_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PIN_CFG_A = {2'h0, IDX_PIN_CFG_A, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PIN_CFG_B = {2'h0, IDX_PIN_CFG_B, 2'h0};

    // ------------------------------------------------------------
    // Configuration field layout: two bits per pin, four pins per reg
    // ------------------------------------------------------------
    localparam int PINS_PER_CFG = 4;
    localparam int CFG_BITS_PER_PIN = 2;
    localparam int CFG_DIR_OFS = 0;
    localparam int CFG_POL_OFS = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_PIN_STATUS = 8'h00;
    localparam logic [REG_W-1:0] RST_PIN_CFG = 8'h00;
    localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_t;

endpackage

// *** src/pin_cell.sv ***
/*
 * One general-purpose pin: input synchroniser, status bit and output
 * driver with selectable asserted polarity.
 * Assumes direction and polarity come from registers on core_clk and
 * that the pad level is asynchronous to core_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_cell (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pad_in,
    input wire logic is_output,
    input wire logic active_high,
    input wire logic wr_hit,
    input wire logic wr_value,
    output logic status_bit,
    output logic pad_out,
    output logic pad_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic sync1_reg;
    logic sync2_reg;
    logic status_reg;
    logic status_next;
    logic pad_out_reg;
    logic pad_out_next;
    logic pad_oe_reg;
    logic pad_oe_next;

    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Status and drive; output level follows the write in the same edge.
    // An input pin holds its last drive so the unused pad net stays quiet.
    always_comb begin
        if (is_output) begin
            status_next = wr_hit ? wr_value : status_reg; // RULE2 RULE5 RULE8
        end else begin
            status_next = (sync2_reg == active_high); // RULE1
        end
        pad_out_next = is_output ? ~(status_next ^ active_high) : pad_out_reg; // RULE2
        pad_oe_next = is_output;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_reg <= 1'b0;
            pad_out_reg <= 1'b0;
            pad_oe_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            pad_out_reg <= pad_out_next;
            pad_oe_reg <= pad_oe_next;
        end
    end

    assign status_bit = status_reg;
    assign pad_out = pad_out_reg;
    assign pad_oe = pad_oe_reg;

endmodule

`default_nettype wire

// *** src/pin_status_bank.sv ***
/*
 * Low pin status bank: eight general-purpose pins behind one status
 * register, with two pin-configuration registers that set direction
 * and asserted polarity, all reached over an APB slave.
 * Assumes a single 40 MHz core_clk, an asynchronous active-high rst,
 * and pads that are resolved outside from out and output enable.
 */
// Local design decision: register access over APB.
// How it works
// RULE1: Input pin sets its status bit while at asserted level, clears otherwise.
// RULE2: Output pin is driven asserted whenever software writes one to its bit.
// RULE3: Pins 0-3 polarity follows bits 1,3,5,7 of first configuration register.
// RULE4: Pins 4-7 polarity follows bits 1,3,5,7 of second configuration register.
// RULE5: Status bit accepts writes only while its pin is an output.
// RULE6: Status register sits at index 21h and resets to 00h.
// RULE7: Status bit n belongs to pin n, one bit per pin.
// RULE8: Output pin status bit reads back the value last written.
`timescale 1ns/100ps
`default_nettype none

module pin_status_bank (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] gen_pin_in,
    output logic [7:0] gen_pin_out,
    output logic [7:0] gen_pin_oe
);

    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    pin_status_pkg::bus_state_t bus_state_reg;
    pin_status_pkg::bus_state_t bus_state_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] cfg_a_reg;
    logic [7:0] cfg_a_next;
    logic [7:0] cfg_b_reg;
    logic [7:0] cfg_b_next;

    // ------------------------------------------------------------
    // Decode and per-pin wires
    // ------------------------------------------------------------
    logic setup_phase;
    logic access_done;
    logic hit_status;
    logic hit_cfg_a;
    logic hit_cfg_b;
    logic mapped;
    logic status_wr;
    logic [7:0] status_bits;
    logic [7:0] pin_is_output;
    logic [7:0] pin_active_high;

    // Setup cycle and completing access edge
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready_reg;

    // Full-word compare; the upper index bits must be zero as well
    assign hit_status = (paddr == pin_status_pkg::ADDR_PIN_STATUS); // RULE6
    assign hit_cfg_a = (paddr == pin_status_pkg::ADDR_PIN_CFG_A);
    assign hit_cfg_b = (paddr == pin_status_pkg::ADDR_PIN_CFG_B);
    assign mapped = hit_status | hit_cfg_a | hit_cfg_b;

    // A write takes effect only at the edge that completes the access
    assign status_wr = access_done & pwrite & hit_status;

    // ------------------------------------------------------------
    // Bus handshake: one wait-free access phase per transfer
    // ------------------------------------------------------------
    // Response is prepared during setup so all outputs come from flops
    always_comb begin
        bus_state_next = bus_state_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        unique case (bus_state_reg)
            pin_status_pkg::BUS_IDLE: begin
                if (setup_phase) begin
                    bus_state_next = pin_status_pkg::BUS_ACCESS;
                    pready_next = 1'b1;
                    pslverr_next = ~mapped;
                    prdata_next = pin_status_pkg::RST_RDATA;
                    if (!pwrite) begin
                        if (hit_status) begin
                            prdata_next = {24'h00_0000, status_bits}; // RULE7 RULE8
                        end else if (hit_cfg_a) begin
                            prdata_next = {24'h00_0000, cfg_a_reg};
                        end else if (hit_cfg_b) begin
                            prdata_next = {24'h00_0000, cfg_b_reg};
                        end
                    end
                end
            end
            pin_status_pkg::BUS_ACCESS: begin
                // Leave on completion, or if the master drops select early
                if (access_done || !psel) begin
                    bus_state_next = pin_status_pkg::BUS_IDLE;
                end else begin
                    pready_next = pready_reg;
                    pslverr_next = pslverr_reg;
                end
            end
            default: begin
                bus_state_next = pin_status_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_state_reg <= pin_status_pkg::BUS_IDLE;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= pin_status_pkg::RST_RDATA;
        end else begin
            bus_state_reg <= bus_state_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // ------------------------------------------------------------
    // Pin-configuration registers
    // ------------------------------------------------------------
    // Plain read/write; a change of direction acts from the next edge
    always_comb begin
        cfg_a_next = cfg_a_reg;
        cfg_b_next = cfg_b_reg;
        if (access_done && pwrite && hit_cfg_a) begin
            cfg_a_next = pwdata[7:0];
        end
        if (access_done && pwrite && hit_cfg_b) begin
            cfg_b_next = pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_a_reg <= pin_status_pkg::RST_PIN_CFG;
            cfg_b_reg <= pin_status_pkg::RST_PIN_CFG;
        end else begin
            cfg_a_reg <= cfg_a_next;
            cfg_b_reg <= cfg_b_next;
        end
    end

    // ------------------------------------------------------------
    // Per-pin field selection and pin cells
    // ------------------------------------------------------------
    // Pins 0-3 take their fields from the first register, 4-7 the second
    genvar gi;
    generate
        for (gi = 0; gi < pin_status_pkg::PIN_COUNT; gi = gi + 1) begin : g_pin
            localparam int SLOT = gi % pin_status_pkg::PINS_PER_CFG;
            localparam int DIR_POS = SLOT * pin_status_pkg::CFG_BITS_PER_PIN
                + pin_status_pkg::CFG_DIR_OFS;
            localparam int POL_POS = SLOT * pin_status_pkg::CFG_BITS_PER_PIN
                + pin_status_pkg::CFG_POL_OFS;
            if (gi < pin_status_pkg::PINS_PER_CFG) begin : g_low
                assign pin_is_output[gi] = cfg_a_reg[DIR_POS];
                assign pin_active_high[gi] = cfg_a_reg[POL_POS]; // RULE3
            end else begin : g_high
                assign pin_is_output[gi] = cfg_b_reg[DIR_POS];
                assign pin_active_high[gi] = cfg_b_reg[POL_POS]; // RULE4
            end

            // Bit n of the write word reaches pin n alone
            pin_cell u_cell (
                .core_clk(core_clk),
                .rst(rst),
                .pad_in(gen_pin_in[gi]),
                .is_output(pin_is_output[gi]),
                .active_high(pin_active_high[gi]),
                .wr_hit(status_wr),
                .wr_value(pwdata[gi]), // RULE7 RULE5
                .status_bit(status_bits[gi]),
                .pad_out(gen_pin_out[gi]),
                .pad_oe(gen_pin_oe[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

endmodule

`default_nettype wire

// *** verif/pin_status_bank_monitor.sv ***
/* Checker for the low pin status bank: bus timing and pin outputs.
   Assumes it is bound into pin_status_bank and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module pin_status_bank_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] gen_pin_in,
    input wire logic [7:0] gen_pin_out,
    input wire logic [7:0] gen_pin_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Completed writes, split by target
    wire logic done_wr = psel && penable && pready && pwrite;
    wire logic is_cfg = paddr == pin_status_pkg::ADDR_PIN_CFG_A ||
        paddr == pin_status_pkg::ADDR_PIN_CFG_B;
    wire logic is_map = is_cfg || paddr == pin_status_pkg::ADDR_PIN_STATUS;
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
        else $error("no ready in access");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_err_unmapped: assert property (pready |-> pslverr == !is_map)
        else $error("pslverr wrong");
    // Config lands at the write edge, the pad flops follow one edge later
    a_oe_cause: assert property ($changed(gen_pin_oe) |->
        $past(done_wr && is_cfg, 2)) else $error("oe moved without cfg write");
    // Status write moves the pad at its own edge, a config write one edge later
    a_out_cause: assert property ($changed(gen_pin_out) |->
        $past(done_wr && is_map) || $past(done_wr && is_cfg, 2))
        else $error("out moved without write");
    a_err_inert: assert property (pready && pslverr |=>
        $stable(gen_pin_out) && $stable(gen_pin_oe)) else $error("refused write moved pins");
    c_err: cover property (pready && pslverr);
    c_st_wr: cover property (done_wr && paddr == pin_status_pkg::ADDR_PIN_STATUS);
    c_oe: cover property ($changed(gen_pin_oe));
endmodule
bind pin_status_bank pin_status_bank_monitor u_mon (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gen_pin_in(gen_pin_in),
    .gen_pin_out(gen_pin_out), .gen_pin_oe(gen_pin_oe));
`default_nettype wire

// *** verif/pin_board.sv ***
/* Board model: pads driven by the device where enabled, else by the board.
   Assumes the board level is set by the bench. */
`timescale 1ns/100ps
`default_nettype none
module pin_board (
    input wire logic [7:0] gen_pin_out,
    input wire logic [7:0] gen_pin_oe,
    input wire logic [7:0] board_level,
    output logic [7:0] gen_pin_in
);
    // Device wins on enabled pads, so output pins loop back their drive
    assign gen_pin_in = (gen_pin_out & gen_pin_oe) | (board_level & ~gen_pin_oe);
endmodule
`default_nettype wire

// *** verif/pin_status_bank_tb.sv ***
/* Self-checking bench for the low pin status bank over APB.
   Assumes zero wait states are not relied on: waits are bounded. */
`timescale 1ns/100ps
`default_nettype none
module pin_status_bank_tb;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [7:0] gen_pin_in, gen_pin_out, gen_pin_oe, board, ca, cb, lvl, w, dm;
    logic e;
    int n_fail, compares;
    localparam logic [11:0] ST = pin_status_pkg::ADDR_PIN_STATUS;
    localparam logic [11:0] CA = pin_status_pkg::ADDR_PIN_CFG_A;
    localparam logic [11:0] CB = pin_status_pkg::ADDR_PIN_CFG_B;
    localparam logic [11:0] RST_ADDR [3] = '{ST, CA, CB};
    pin_status_bank u_pin_status_bank (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gen_pin_in(gen_pin_in),
        .gen_pin_out(gen_pin_out), .gen_pin_oe(gen_pin_oe));
    pin_board u_pin_board (.gen_pin_out(gen_pin_out), .gen_pin_oe(gen_pin_oe),
        .board_level(board), .gen_pin_in(gen_pin_in));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic final_report;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected status (m=0), drive level (m=1) or direction mask (m=2)
    function automatic logic [7:0] expv(logic [7:0] a, logic [7:0] b, logic [7:0] l,
        logic [7:0] v, int m);
        logic [7:0] c;
        logic [7:0] r;
        int s;
        for (int k = 0; k < 8; k++) begin
            c = (k < 4) ? a : b;
            s = 2 * (k % 4);
            r[k] = (m == 2) ? c[s] : (m == 1) ? (c[s+1] ? v[k] : ~v[k]) :
                (c[s] ? v[k] : (c[s+1] ? l[k] : ~l[k]));
        end
        return r;
    endfunction
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        final_report();
    end
    initial begin
        void'($urandom(32'hc82128cc));
        {rst, psel, penable, pwrite, paddr, pwdata, board} = {3'b100, 1'b0, 12'h0, 32'h0, 8'hff};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        // Reset values; board idles high, so active-low inputs read clear
        for (int j = 0; j < 3; j++) begin
            apb(1'b0, RST_ADDR[j], 32'h0);
            chk(d, 32'h0);
        end
        apb(1'b1, 12'h088, 32'hff); // unmapped write must be refused
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h088, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(d, 32'h0);
        // Corner configurations first, then random ones
        for (int i = 0; i < 24; i++) begin
            case (i)
                0: {ca, cb} = 16'h0000;
                1: {ca, cb} = 16'hffff;
                2: {ca, cb} = 16'h5555;
                3: {ca, cb} = 16'haaaa;
                default: {ca, cb} = 16'($urandom);
            endcase
            lvl = 8'($urandom);
            w = 8'($urandom);
            board <= lvl;
            apb(1'b1, CA, {24'h0, ca});
            apb(1'b1, CB, {24'h0, cb});
            apb(1'b1, ST, {$urandom} & 32'hffffff00 | {24'h0, w});
            chk({31'h0, e}, 32'h0);
            repeat (4) @(posedge core_clk);
            apb(1'b0, ST, 32'h0);
            chk(d, {24'h0, expv(ca, cb, lvl, w, 0)});
            dm = expv(ca, cb, lvl, w, 2);
            chk({24'h0, gen_pin_oe}, {24'h0, dm});
            chk({24'h0, (gen_pin_out ^ expv(ca, cb, lvl, w, 1)) & dm}, 32'h0);
        end
        final_report();
    end
endmodule
`default_nettype wire
